// ### logic/mid_decoder.sv
// Instruction decode and execute core with AXI4-Lite control
// Assumes a combinational program memory on prog_addr/prog_data
`timescale 1ns/1ps
`default_nettype none
`include "mid_defines.svh"

// How it works
// RULE1: Each program word is 13 bits: opcode field then operand fields.
// RULE2: A plain instruction completes in one cycle of two clock periods.
// RULE3: Writes to the program counter register cost one or two cycles.
// RULE4: Bit clear, set, skip-if-clear and skip-if-set on any register bit.
// RULE5: Port registers sit in the register field like ordinary registers.
// RULE6: A six-bit field picks one register for register operations.
// RULE7: Literals are 8 bits for accumulator ops, 10 bits for call/jump.
// RULE8: Sleep clears watchdog and stops; watchdog clear only clears; both set flags.
// RULE9: Interrupt enable, disable, return, and return with enable.
// RULE10: Control register moves reach only valid control registers, no flags.
// RULE11: Add and subtract update zero, carry and half carry.
// RULE12: Logic, complement, step, clear and move update only zero.
// RULE13: Decrement and skip next when zero, flags untouched.
// RULE14: Increment and skip next when zero, flags untouched.
// RULE15: Rotates move through carry in either direction.
// RULE16: Nibble swap, no flags.
// RULE17: Call pushes return address; call and jump load page plus literal.
// RULE18: Return with literal loads accumulator and pops the program counter.
// RULE19: A 13-bit identification word is kept with no behaviour.
// RULE20: Cycle select 0 gives one cycle, 1 gives two; default two.
// RULE21: Bit six picks destination: 0 accumulator, 1 register.
// RULE22: A skip turns the next instruction into a dead cycle.
module mid_decoder
    import mid_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    output logic [11:0] prog_addr,
    input wire logic [12:0] prog_data,
    input wire logic [23:0] port_in,
    output logic [23:0] port_out,
    output logic watchdog_clear,
    output logic osc_stop,
    output logic irq_enabled,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // Arithmetic helper
    function automatic logic [9:0] f_add(
        input logic [7:0] x,
        input logic [7:0] y,
        input logic cin
    );
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
        return {lo[4], hi[4], hi[3:0], lo[3:0]};
    endfunction

    // ==========================================================
    // State
    logic [7:0] file_q [0:63];
    logic [7:0] ioc_q [0:15];
    logic [11:0] stack_q [0:7];
    logic [2:0] sp_q;
    logic [2:0] sp_dec;
    logic [11:0] pc_q;
    logic [7:0] acc_q;
    logic [7:0] core_control_register_q;
    logic [7:0] st_q;
    logic [12:0] ir_q;
    logic ie_q;
    logic ph_q;
    mid_state_t state_q;
    logic [1:0] ctrl_q;
    logic wake_q;
    logic [12:0] cid_q;
    logic [23:0] pin_s1_q;
    logic [23:0] pin_s2_q;
    logic wdc_q;
    mid_exec_t ex;
    logic [7:0] rv;
    logic [7:0] k8;
    logic [7:0] mask;
    logic [9:0] sum;
    logic [8:0] dt;
    logic [5:0] ra;
    logic run;
    logic exec_now;
    logic fetch_now;
    logic pc_chg;

    assign ra = ir_q[5:0];
    assign k8 = ir_q[7:0];
    assign mask = 8'h01 << ir_q[8:6];
    assign run = ctrl_q[`MID_CTL_RUN];
    assign sp_dec = sp_q - 3'h1;
    assign fetch_now = run && state_q == MID_RUN && ph_q != `MID_PH_LAST;
    assign exec_now = run && state_q == MID_RUN && ph_q == `MID_PH_LAST;
    assign pc_chg = ex.jump || ex.pop || (ex.wr_r && ra == `MID_R_PC);
    assign prog_addr = pc_q;
    assign port_out = {file_q[`MID_R_PORT2], file_q[`MID_R_PORT1], file_q[`MID_R_PORT0]};
    assign watchdog_clear = wdc_q;
    assign osc_stop = state_q == MID_SLEEP;
    assign irq_enabled = ie_q;

    // ==========================================================
    // Pin input synchroniser
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_s1_q <= 24'h000000;
            pin_s2_q <= 24'h000000;
        end else begin
            pin_s1_q <= port_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // Operand read
    always_comb begin
        case (ra) // [RULE6] [RULE5]
            `MID_R_PC: rv = pc_q[7:0];
            `MID_R_ST: rv = st_q;
            `MID_R_PORT0: rv = pin_s2_q[7:0];
            `MID_R_PORT1: rv = pin_s2_q[15:8];
            `MID_R_PORT2: rv = pin_s2_q[23:16];
            default: rv = file_q[ra];
        endcase
    end

    // ==========================================================
    // Decode and compute
    always_comb begin
        ex = '0;
        sum = 10'h000;
        dt = {1'b0, acc_q};
        if (ir_q[12]) begin
            if (!ir_q[11]) begin
                ex.jump = 1'b1; // [RULE7] [RULE17]
                ex.push = !ir_q[10]; // [RULE17]
            end else begin
                ex.wr_a = 1'b1; // [RULE7]
                case (ir_q[10:8])
                    3'b000: ex.res = k8;
                    3'b001: begin
                        ex.res = acc_q | k8;
                        ex.upd_z = 1'b1;
                    end
                    3'b010: begin
                        ex.res = acc_q & k8;
                        ex.upd_z = 1'b1;
                    end
                    3'b011: begin
                        ex.res = acc_q ^ k8;
                        ex.upd_z = 1'b1;
                    end
                    3'b100: begin
                        ex.res = k8; // [RULE18]
                        ex.pop = 1'b1;
                    end
                    3'b101: sum = f_add(k8, ~acc_q, 1'b1);
                    3'b111: sum = f_add(k8, acc_q, 1'b0);
                    default: ex.wr_a = 1'b0;
                endcase
                if (ir_q[10:8] == 3'b101 || ir_q[10:8] == 3'b111) begin
                    ex.res = sum[7:0];
                    ex.c = sum[8];
                    ex.dc = sum[9];
                    ex.upd_z = 1'b1;
                    ex.upd_c = 1'b1;
                    ex.upd_dc = 1'b1;
                end
            end
        end else if (ir_q[11]) begin
            case (ir_q[10:9]) // [RULE4]
                2'b00: begin
                    ex.res = rv & ~mask;
                    ex.wr_r = 1'b1;
                end
                2'b01: begin
                    ex.res = rv | mask;
                    ex.wr_r = 1'b1;
                end
                2'b10: ex.skip = (rv & mask) == 8'h00;
                default: ex.skip = (rv & mask) != 8'h00;
            endcase
        end else if (ir_q[10:8] == 3'b000) begin
            case (ir_q[7:6])
                2'b00: begin
                    case (ra)
                        `MID_OP_NOP: ex.res = 8'h00;
                        `MID_OP_DAA: begin
                            if (acc_q[3:0] > 4'h9) begin
                                dt = dt + 9'h006;
                            end
                            if (dt > 9'h099 || st_q[`MID_ST_C]) begin
                                dt = dt + 9'h060;
                                ex.c = 1'b1;
                            end
                            ex.res = dt[7:0];
                            ex.wr_a = 1'b1;
                            ex.upd_c = 1'b1;
                        end
                        `MID_OP_CONTW: ex.core_control_register_wr = 1'b1;
                        `MID_OP_SLEEP: ex.sleep = 1'b1; // [RULE8]
                        `MID_OP_WATCHDOG_CLEAR_OP: ex.watchdog_clear_op = 1'b1; // [RULE8]
                        `MID_OP_ENI: ex.ie_set = 1'b1; // [RULE9]
                        `MID_OP_IRQ_DISABLE_OP: ex.ie_clr = 1'b1; // [RULE9]
                        `MID_OP_RET: ex.pop = 1'b1; // [RULE9]
                        `MID_OP_RETURN_IRQ_OP: begin
                            ex.pop = 1'b1; // [RULE9]
                            ex.ie_set = 1'b1;
                        end
                        `MID_OP_CONTR: begin
                            ex.res = core_control_register_q;
                            ex.wr_a = 1'b1;
                        end
                        default: begin
                            if (ir_q[5:4] == 2'b00 && ir_q[3:0] >= `MID_IOC_FIRST) begin
                                ex.ioc_wr = 1'b1; // [RULE10]
                            end else if (ir_q[5:4] == 2'b01 && ir_q[3:0] >= `MID_IOC_FIRST) begin
                                ex.res = ioc_q[ir_q[3:0]]; // [RULE10]
                                ex.wr_a = 1'b1;
                            end
                        end
                    endcase
                end
                2'b01: begin
                    ex.res = acc_q;
                    ex.wr_r = 1'b1;
                end
                2'b10: begin
                    ex.wr_a = 1'b1; // [RULE12]
                    ex.upd_z = 1'b1;
                end
                default: begin
                    ex.wr_r = 1'b1; // [RULE12]
                    ex.upd_z = 1'b1;
                end
            endcase
        end else begin
            ex.wr_a = !ir_q[6]; // [RULE21]
            ex.wr_r = ir_q[6]; // [RULE21]
            case ({ir_q[10:8], ir_q[7]})
                4'b0010: begin
                    sum = f_add(rv, ~acc_q, 1'b1); // [RULE11]
                    ex.upd_c = 1'b1;
                    ex.upd_dc = 1'b1;
                end
                4'b0011: ex.res = rv - 8'h01;
                4'b0100: ex.res = acc_q | rv;
                4'b0101: ex.res = acc_q & rv;
                4'b0110: ex.res = acc_q ^ rv;
                4'b0111: begin
                    sum = f_add(acc_q, rv, 1'b0); // [RULE11]
                    ex.upd_c = 1'b1;
                    ex.upd_dc = 1'b1;
                end
                4'b1000: ex.res = rv;
                4'b1001: ex.res = ~rv;
                4'b1010: ex.res = rv + 8'h01;
                4'b1011: begin
                    ex.res = rv - 8'h01; // [RULE13]
                    ex.skip = ex.res == 8'h00;
                end
                4'b1100: begin
                    ex.res = {st_q[`MID_ST_C], rv[7:1]}; // [RULE15]
                    ex.c = rv[0];
                    ex.upd_c = 1'b1;
                end
                4'b1101: begin
                    ex.res = {rv[6:0], st_q[`MID_ST_C]}; // [RULE15]
                    ex.c = rv[7];
                    ex.upd_c = 1'b1;
                end
                4'b1110: ex.res = {rv[3:0], rv[7:4]}; // [RULE16]
                default: begin
                    ex.res = rv + 8'h01; // [RULE14]
                    ex.skip = ex.res == 8'h00;
                end
            endcase
            if (ex.upd_dc) begin
                ex.res = sum[7:0];
                ex.c = sum[8];
                ex.dc = sum[9];
            end
            ex.upd_z = ir_q[10:8] != 3'b110 && ir_q[10:8] != 3'b111 &&
                       {ir_q[10:8], ir_q[7]} != 4'b1011; // [RULE12]
        end
    end

    // ==========================================================
    // Sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= MID_RUN;
            ph_q <= 1'b0;
        end else begin
            case (state_q)
                MID_RUN: begin
                    if (run) begin
                        ph_q <= ~ph_q; // [RULE2]
                        if (exec_now && ex.sleep) begin
                            state_q <= MID_SLEEP;
                        end else if (exec_now && ex.skip) begin
                            state_q <= MID_DEAD; // [RULE22]
                        end else if (exec_now && pc_chg && ctrl_q[`MID_CTL_CYC]) begin
                            state_q <= MID_DEAD; // [RULE3] [RULE20]
                        end
                    end
                end
                MID_DEAD: begin
                    if (run) begin
                        ph_q <= ~ph_q;
                        if (ph_q == `MID_PH_LAST) begin
                            state_q <= MID_RUN;
                        end
                    end
                end
                MID_SLEEP: begin
                    ph_q <= 1'b0;
                    if (wake_q) begin
                        state_q <= MID_RUN;
                    end
                end
                default: state_q <= MID_RUN;
            endcase
        end
    end

    // ==========================================================
    // Fetch and program counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ir_q <= 13'h0000;
        end else if (fetch_now) begin
            ir_q <= prog_data; // [RULE1]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_q <= 12'h000;
        end else if (exec_now) begin
            if (ex.jump) begin
                pc_q <= {st_q[`MID_ST_PG_HI:`MID_ST_PG_LO], ir_q[9:0]}; // [RULE17]
            end else if (ex.pop) begin
                pc_q <= stack_q[sp_dec]; // [RULE18] [RULE9]
            end else if (ex.wr_r && ra == `MID_R_PC) begin
                pc_q <= {pc_q[11:8], ex.res}; // [RULE3]
            end else if (ex.skip) begin
                pc_q <= pc_q + 12'h002; // [RULE22]
            end else begin
                pc_q <= pc_q + 12'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sp_q <= 3'h0;
        end else if (exec_now && ex.push) begin
            stack_q[sp_q] <= pc_q + 12'h001; // [RULE17]
            sp_q <= sp_q + 3'h1;
        end else if (exec_now && ex.pop) begin
            sp_q <= sp_dec;
        end
    end

    // ==========================================================
    // Register file, accumulator, control registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 64; i++) begin
                file_q[i] <= 8'h00;
            end
        end else if (exec_now && ex.wr_r && ra != `MID_R_PC && ra != `MID_R_ST) begin
            file_q[ra] <= ex.res; // [RULE6]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            acc_q <= 8'h00;
            core_control_register_q <= 8'h00;
        end else if (exec_now) begin
            if (ex.wr_a) begin
                acc_q <= ex.res;
            end
            if (ex.core_control_register_wr) begin
                core_control_register_q <= acc_q;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                ioc_q[i] <= 8'h00;
            end
        end else if (exec_now && ex.ioc_wr) begin
            ioc_q[ir_q[3:0]] <= acc_q; // [RULE10]
        end
    end

    // ==========================================================
    // Status flags, interrupt enable, watchdog pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= `MID_ST_RST;
        end else if (exec_now) begin
            if (ex.wr_r && ra == `MID_R_ST) begin
                st_q <= ex.res;
            end
            if (ex.upd_z) begin
                st_q[`MID_ST_Z] <= ex.res == 8'h00; // [RULE11] [RULE12]
            end
            if (ex.upd_c) begin
                st_q[`MID_ST_C] <= ex.c; // [RULE11] [RULE15]
            end
            if (ex.upd_dc) begin
                st_q[`MID_ST_DC] <= ex.dc; // [RULE11]
            end
            if (ex.sleep || ex.watchdog_clear_op) begin
                st_q[`MID_ST_T] <= 1'b1; // [RULE8]
                st_q[`MID_ST_P] <= ex.watchdog_clear_op;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ie_q <= 1'b0;
            wdc_q <= 1'b0;
        end else begin
            wdc_q <= exec_now && (ex.sleep || ex.watchdog_clear_op); // [RULE8]
            if (exec_now && ex.ie_set) begin
                ie_q <= 1'b1; // [RULE9]
            end else if (exec_now && ex.ie_clr) begin
                ie_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_ok_q;
    logic w_ok_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;

    assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
    assign s_axi_wready = !w_ok_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MID_RESP_OKAY;
            ctrl_q <= `MID_CTL_RST;
            wake_q <= 1'b0;
            cid_q <= `MID_CID_RST;
        end else begin
            wake_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (aw_ok_q && w_ok_q) begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MID_RESP_OKAY;
                case (aw_q)
                    `MID_A_CTRL: begin
                        if (ws_q[0]) begin
                            ctrl_q <= wd_q[1:0]; // [RULE20]
                            wake_q <= wd_q[`MID_CTL_WAKE];
                        end
                    end
                    `MID_A_CID: begin
                        if (ws_q[0]) begin
                            cid_q[7:0] <= wd_q[7:0]; // [RULE19]
                        end
                        if (ws_q[1]) begin
                            cid_q[12:8] <= wd_q[12:8];
                        end
                    end
                    `MID_A_STAT, `MID_A_PC: s_axi_bresp <= `MID_RESP_OKAY;
                    default: s_axi_bresp <= `MID_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MID_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MID_RESP_OKAY;
            case (s_axi_araddr)
                `MID_A_CTRL: s_axi_rdata <= {30'h00000000, ctrl_q};
                `MID_A_STAT: s_axi_rdata <= {14'h0000, osc_stop, ie_q, st_q, acc_q};
                `MID_A_PC: s_axi_rdata <= {20'h00000, pc_q};
                `MID_A_CID: s_axi_rdata <= {19'h00000, cid_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `MID_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### logic/mid_defines.svh
// Constants for the instruction decode and execute block
// Assumes inclusion by bare name from the package and the core
`ifndef MID_DEFINES_SVH
`define MID_DEFINES_SVH
// Oscillator periods per instruction cycle, last phase index
`define MID_OSC_PER_CYC 2
`define MID_PH_LAST 1'b1
// Register file indexes
`define MID_R_PC 6'h02
`define MID_R_ST 6'h03
`define MID_R_PORT0 6'h05
`define MID_R_PORT1 6'h06
`define MID_R_PORT2 6'h07
`define MID_IOC_FIRST 4'h5
// Status register bits and reset value
`define MID_ST_C 0
`define MID_ST_DC 1
`define MID_ST_Z 2
`define MID_ST_P 3
`define MID_ST_T 4
`define MID_ST_PG_HI 6
`define MID_ST_PG_LO 5
`define MID_ST_RST 8'h18
// Special operation codes in the low six bits
`define MID_OP_NOP 6'h00
`define MID_OP_DAA 6'h01
`define MID_OP_CONTW 6'h02
`define MID_OP_SLEEP 6'h03
`define MID_OP_WATCHDOG_CLEAR_OP 6'h04
`define MID_OP_ENI 6'h10
`define MID_OP_IRQ_DISABLE_OP 6'h11
`define MID_OP_RET 6'h12
`define MID_OP_RETURN_IRQ_OP 6'h13
`define MID_OP_CONTR 6'h14
// Bus register byte addresses
`define MID_A_CTRL 8'h00
`define MID_A_STAT 8'h04
`define MID_A_PC 8'h08
`define MID_A_CID 8'h0c
// Control bits and reset value (run off, two-cycle select)
`define MID_CTL_RUN 0
`define MID_CTL_CYC 1
`define MID_CTL_WAKE 2
`define MID_CTL_RST 2'b10
// Identification word reset value, arbitrary
`define MID_CID_RST 13'h0155
`define MID_RESP_OKAY 2'b00
`define MID_RESP_SLVERR 2'b10
`endif

// ### logic/mid_pkg.sv
// Types shared by the decode and execute block
// Assumes the defines header is on the include path
`default_nettype none
`include "mid_defines.svh"
package mid_pkg;
    typedef enum logic [1:0] {
        MID_RUN,
        MID_DEAD,
        MID_SLEEP
    } mid_state_t;

    typedef struct packed {
        logic [7:0] res;
        logic wr_a;
        logic wr_r;
        logic upd_z;
        logic upd_c;
        logic upd_dc;
        logic c;
        logic dc;
        logic skip;
        logic jump;
        logic push;
        logic pop;
        logic ioc_wr;
        logic core_control_register_wr;
        logic sleep;
        logic watchdog_clear_op;
        logic ie_set;
        logic ie_clr;
    } mid_exec_t;
endpackage
`default_nettype wire

// ### dv/mid_decoder_properties.sv
// Port checks for the decode core and its register bus
// Assumes binding onto mid_decoder by port name
`timescale 1ns/1ps
`default_nettype none
module mid_decoder_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [11:0] prog_addr,
    input wire logic watchdog_clear,
    input wire logic osc_stop,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ==========
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wdc_pulse: assert property (watchdog_clear |=> !watchdog_clear)
        else $error("wdc too long");
    a_sleep_clear: assert property ($rose(osc_stop) |-> ##[0:1] watchdog_clear)
        else $error("sleep no wdc");
    a_sleep_hold: assert property (osc_stop |=> $stable(prog_addr))
        else $error("pc moved asleep");
    a_pc_two: assert property ($changed(prog_addr) |=> $stable(prog_addr))
        else $error("cycle short");
    a_wr_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("bvalid late");
    a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write open");
    a_rd_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("rvalid late");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read open");
endmodule
bind mid_decoder mid_decoder_props chk_u (.*);
`default_nettype wire

// ### dv/mid_prog_mem.sv
// Program memory that answers the fetch address at once
// Assumes the bench loads mem before the core runs
`timescale 1ns/1ps
`default_nettype none
module mid_prog_mem (
    input wire logic [11:0] prog_addr,
    output logic [12:0] prog_data
);
    logic [12:0] mem [4096];
    assign prog_data = mem[prog_addr];
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the decode core
// Assumes design, package, memory model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0, reset = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [23:0] port_in = 24'h5a3c01, port_out;
    logic [11:0] prog_addr;
    logic [12:0] prog_data;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic watchdog_clear, osc_stop, irq_enabled;
    logic [12:0] prog [9] = '{13'h180f, 13'h1f01, 13'h0010, 13'h0004, 13'h0048,
        13'h0f08, 13'h0003, 13'h1010, 13'h0003};
    int num_errors = 0, n_compared = 0, n0, n1;
    mid_decoder dut_u (.*);
    mid_prog_mem pm_u (.*);
    initial forever #20 core_clk = ~core_clk;
    // ==========
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta = 1'b0;
        logic tw = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!(ta && tw));
        while (!s_axi_bvalid) @(posedge core_clk);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Reset, start the core and count clocks until it sleeps
    task automatic run(input logic sel, output int n);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        wr(8'h00, {30'h0, sel, 1'b1});
        n = 0;
        while (!osc_stop && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        chk("asleep", 32'h1, {31'h0, osc_stop});
    endtask
    // ==========
    // Tests
    initial begin
        foreach (pm_u.mem[i]) pm_u.mem[i] = 13'h0000;
        foreach (prog[i]) pm_u.mem[i] = prog[i];
        pm_u.mem[16] = 13'h0546;
        pm_u.mem[17] = 13'h1c55;
        run(1'b0, n0);
        rd(8'h0c);
        chk("id reset", 32'h155, d);
        wr(8'h0c, 32'h1abc);
        rd(8'h0c);
        chk("id", 32'h1abc, d);
        rd(8'h10);
        chk("unmapped resp", 32'h2, {30'h0, r});
        wr(8'h10, 32'h0);
        chk("unmapped wr resp", 32'h2, {30'h0, r});
        wr(8'h00, 32'h4);
        @(posedge core_clk);
        chk("woken", 32'h0, {31'h0, osc_stop});
        run(1'b1, n1);
        rd(8'h04);
        chk("status", 32'h31255, d);
        chk("irq", 32'h1, {31'h0, irq_enabled});
        chk("port", 32'h3d00, {8'h0, port_out});
        chk("cycle gap", 32'h4, 32'(n1 - n0));
        test_done;
    end
    // Whole run needs well under a thousand clocks
    initial begin
        #400000;
        num_errors++;
        test_done;
    end
endmodule
`default_nettype wire
